// ==== logic/ttx_exec.sv ====
`timescale 1ns/1ps
`default_nettype none
// trap, tlb maintenance and xor execute stage
module ttx_exec #(
  parameter int ENTRIES = 32,
  parameter int IW = 5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic valid_i, // instruction presented
  input wire logic mode64_i, // 64-bit operation enabled
  input wire logic [31:0] instr_i, // raw instruction word
  input wire ttx_pkg::ttx_word_t src1_val_i, // first_source_reg value
  input wire ttx_pkg::ttx_word_t src2_val_i, // second_source_reg value
  input wire logic [IW-1:0] random_i, // random register value
  input wire logic cp_we_i, // software write of control regs
  input wire logic [1:0] cp_sel_i, // 0 hi,1 lo0,2 lo1,3 mask
  input wire logic [31:0] index_wr_i, // index written by software
  input wire logic index_we_i, // index write strobe
  input wire ttx_pkg::ttx_word_t cp_wdata_i, // control reg write data
  output logic trap_req_o, // precise trap request pulse
  output logic retire_o, // instruction retired pulse
  output logic gpr_we_o, // destination write pulse
  output logic [4:0] gpr_waddr_o, // destination register
  output ttx_pkg::ttx_word_t gpr_wdata_o, // destination data
  output logic [31:0] index_o, // index register
  output ttx_pkg::ttx_word_t entry_high_reg_o,
  output ttx_pkg::ttx_word_t entry_low_even_reg_o,
  output ttx_pkg::ttx_word_t entry_low_odd_reg_o,
  output ttx_pkg::ttx_word_t page_mask_reg_o
);
  import ttx_pkg::*;
  `include "ttx_defines.svh"
  initial begin
    if (IW > 6 || ENTRIES > (1 << IW)) $error("bad index width");
  end
  // instruction fields
  logic [5:0] opc;
  logic [4:0] src1_f;
  logic [4:0] src2_f;
  logic [4:0] rd_f;
  logic [5:0] fn;
  logic [15:0] imm;
  assign opc = instr_i[31:26];
  assign src1_f = instr_i[25:21];
  assign src2_f = instr_i[20:16];
  assign rd_f = instr_i[15:11];
  assign fn = instr_i[5:0];
  assign imm = instr_i[15:0];
  // operands narrowed in 32-bit mode
  ttx_word_t a;
  ttx_word_t b;
  ttx_word_t simm;
  assign simm = {{48{imm[15]}}, imm};
  always_comb begin
    // low word sign-extended in 32-bit mode
    if (mode64_i) begin
      a = src1_val_i;
      b = src2_val_i;
    end else begin
      a = {{32{src1_val_i[31]}}, src1_val_i[31:0]};
      b = {{32{src2_val_i[31]}}, src2_val_i[31:0]};
    end
  end
  // decode and trap condition; code field bits 15:6 unused
  ttx_op_e op;
  logic cond;
  always_comb begin
    op = TTX_NONE;
    cond = 1'b0;
    case (opc)
      `TTX_OP_REG_REG: begin
        case (fn)
          `TTX_FN_GE_U: begin
            op = TTX_TRAP;
            cond = a >= b;
          end
          `TTX_FN_LT_S: begin
            op = TTX_TRAP;
            cond = $signed(a) < $signed(b);
          end
          `TTX_FN_LT_U: begin
            op = TTX_TRAP;
            cond = a < b;
          end
          `TTX_FN_NE: begin
            op = TTX_TRAP;
            cond = a != b;
          end
          `TTX_FN_XOR: op = TTX_XOR;
          default: op = TTX_NONE;
        endcase
      end
      `TTX_OP_REG_IMM: begin
        case (src2_f)
          `TTX_SUB_LT_IMM_S: begin
            op = TTX_TRAP;
            cond = $signed(a) < $signed(simm);
          end
          `TTX_SUB_LT_IMM_U: begin
            op = TTX_TRAP;
            cond = a < simm;
          end
          `TTX_SUB_NE_IMM: begin
            op = TTX_TRAP;
            cond = a != simm;
          end
          default: op = TTX_NONE;
        endcase
      end
      `TTX_OP_XOR_IMM: op = TTX_XOR;
      `TTX_OP_SYS_COP: begin
        if (src1_f[4]) begin
          case (fn)
            `TTX_CP_PROBE: op = TTX_PROBE;
            `TTX_CP_READ: op = TTX_READ;
            `TTX_CP_WR_IDX: op = TTX_WRI;
            `TTX_CP_WR_RND: op = TTX_WRR;
            default: op = TTX_NONE;
          endcase
        end
      end
      default: op = TTX_NONE;
    endcase
  end
  logic fire;
  assign fire = valid_i && op != TTX_NONE;
  // trap request and retire, trapping instruction never retires
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trap_req_o <= 1'b0;
      retire_o <= 1'b0;
    end else begin
      trap_req_o <= fire && op == TTX_TRAP && cond;
      retire_o <= fire && !(op == TTX_TRAP && cond);
    end
  end
  // xor results
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gpr_we_o <= 1'b0;
      gpr_waddr_o <= 5'h00;
      gpr_wdata_o <= 64'h0;
    end else begin
      gpr_we_o <= fire && op == TTX_XOR;
      if (opc == `TTX_OP_XOR_IMM) begin
        gpr_waddr_o <= src2_f;
        gpr_wdata_o <= src1_val_i ^ {48'h0, imm};
      end else begin
        gpr_waddr_o <= rd_f;
        gpr_wdata_o <= src1_val_i ^ src2_val_i;
      end
    end
  end
  // tlb store; index bits above width wrap, results unspecified
  logic tlb_we;
  logic [IW-1:0] tlb_waddr;
  logic [63:0] r_mask, r_hi, r_lo0, r_lo1;
  logic r_g, hit;
  logic [IW-1:0] hit_idx;
  logic wg;
  assign tlb_we = fire && (op == TTX_WRI || op == TTX_WRR);
  assign tlb_waddr = (op == TTX_WRR) ? random_i : index_o[IW-1:0];
  assign wg = entry_low_even_reg_o[`TTX_LO_G_BIT] &
              entry_low_odd_reg_o[`TTX_LO_G_BIT];
  ttx_tlb_mem #(.ENTRIES(ENTRIES), .IW(IW)) u_mem (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .we_i(tlb_we),
    .waddr_i(tlb_waddr),
    .wmask_i(page_mask_reg_o),
    .whi_i(entry_high_reg_o),
    .wlo0_i(entry_low_even_reg_o),
    .wlo1_i(entry_low_odd_reg_o),
    .wg_i(wg),
    .raddr_i(index_o[IW-1:0]),
    .probe_hi_i(entry_high_reg_o),
    .rmask_o(r_mask),
    .rhi_o(r_hi),
    .rlo0_o(r_lo0),
    .rlo1_o(r_lo1),
    .rg_o(r_g),
    .hit_o(hit),
    .hit_idx_o(hit_idx)
  );
  // read pending one cycle after issue; control regs load the entry one cycle later
  logic read_pend_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) read_pend_ff <= 1'b0;
    else read_pend_ff <= fire && op == TTX_READ;
  end
  // index register: software write, probe result
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      index_o <= 32'h0;
    end else if (fire && op == TTX_PROBE) begin
      if (hit) index_o <= 32'(hit_idx);
      else index_o <= 32'h1 << `TTX_IDX_MISS_BIT;
    end else if (index_we_i) begin
      index_o <= index_wr_i;
    end
  end
  // control registers: tlb read wins over software write
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      entry_high_reg_o <= 64'h0;
      entry_low_even_reg_o <= 64'h0;
      entry_low_odd_reg_o <= 64'h0;
      page_mask_reg_o <= 64'h0;
    end else if (read_pend_ff) begin
      page_mask_reg_o <= r_mask;
      entry_high_reg_o <= r_hi;
      entry_low_even_reg_o <= {r_lo0[63:1], r_g};
      entry_low_odd_reg_o <= {r_lo1[63:1], r_g};
    end else if (cp_we_i) begin
      case (cp_sel_i)
        2'h0: entry_high_reg_o <= cp_wdata_i;
        2'h1: entry_low_even_reg_o <= cp_wdata_i;
        2'h2: entry_low_odd_reg_o <= cp_wdata_i;
        default: page_mask_reg_o <= cp_wdata_i;
      endcase
    end
  end
  // assertions
  property p_trap_no_retire;
    @(posedge clk_i) disable iff (!rst_n_i) trap_req_o |-> !retire_o;
  endproperty
  a_trap_no_retire: assert property (p_trap_no_retire)
    else $error("trap and retire together");
  property p_trap_ge_unsigned;
    @(posedge clk_i) disable iff (!rst_n_i)
      (valid_i && opc == 6'h00 && fn == 6'h31 && mode64_i &&
       src1_val_i >= src2_val_i) |=> trap_req_o;
  endproperty
  a_trap_ge_unsigned: assert property (p_trap_ge_unsigned)
    else $error("unsigned ge trap missing");
  property p_tlt;
    @(posedge clk_i) disable iff (!rst_n_i)
      (valid_i && opc == 6'h00 && fn == 6'h32 && mode64_i)
      |=> trap_req_o == $past($signed(src1_val_i) < $signed(src2_val_i));
  endproperty
  a_tlt: assert property (p_tlt)
    else $error("signed lt trap wrong");
  property p_tne;
    @(posedge clk_i) disable iff (!rst_n_i)
      (valid_i && opc == 6'h00 && fn == 6'h36 &&
       src1_val_i[31:0] == src2_val_i[31:0] && !mode64_i) |=> !trap_req_o;
  endproperty
  a_tne: assert property (p_tne)
    else $error("not-equal trap on equal low words");
  property p_xor;
    @(posedge clk_i) disable iff (!rst_n_i)
      (valid_i && opc == 6'h00 && fn == 6'h26) |=>
        gpr_we_o && !trap_req_o &&
        gpr_wdata_o == ($past(src1_val_i) ^ $past(src2_val_i));
  endproperty
  a_xor: assert property (p_xor)
    else $error("xor result wrong");
  property p_xor_immediate;
    @(posedge clk_i) disable iff (!rst_n_i)
      (valid_i && opc == 6'h0e) |=> gpr_we_o &&
        gpr_wdata_o[63:16] == $past(src1_val_i[63:16]);
  endproperty
  a_xor_immediate: assert property (p_xor_immediate)
    else $error("xor immediate touched upper bits");
  property p_probe_miss;
    @(posedge clk_i) disable iff (!rst_n_i)
      (valid_i && opc == 6'h10 && src1_f[4] && fn == 6'h08 && !hit)
      |=> index_o[31];
  endproperty
  a_probe_miss: assert property (p_probe_miss)
    else $error("probe miss bit not set");
  property p_read_g;
    @(posedge clk_i) disable iff (!rst_n_i)
      (valid_i && opc == 6'h10 && src1_f[4] && fn == 6'h01) |=> ##1
        entry_low_even_reg_o[0] == entry_low_odd_reg_o[0];
  endproperty
  a_read_g: assert property (p_read_g)
    else $error("global bit differs after read");
endmodule
`default_nettype wire

// ==== logic/ttx_defines.svh ====
`ifndef TTX_DEFINES_SVH
`define TTX_DEFINES_SVH
`define TTX_OP_REG_REG 6'h00
`define TTX_OP_REG_IMM 6'h01
`define TTX_OP_XOR_IMM 6'h0e
`define TTX_OP_SYS_COP 6'h10
`define TTX_FN_GE_U 6'h31
`define TTX_FN_LT_S 6'h32
`define TTX_FN_LT_U 6'h33
`define TTX_FN_NE 6'h36
`define TTX_FN_XOR 6'h26
`define TTX_SUB_LT_IMM_S 5'h0a
`define TTX_SUB_LT_IMM_U 5'h0b
`define TTX_SUB_NE_IMM 5'h0e
`define TTX_CP_READ 6'h01
`define TTX_CP_WR_IDX 6'h02
`define TTX_CP_WR_RND 6'h06
`define TTX_CP_PROBE 6'h08
`define TTX_IDX_MISS_BIT 31
`define TTX_LO_G_BIT 0
`define TTX_HI_VPN_LSB 13
`define TTX_HI_ASID_MSB 7
`endif

// ==== logic/ttx_pkg.sv ====
package ttx_pkg;
  // operation chosen by decode
  typedef enum logic [3:0] {
    TTX_NONE = 4'h0,
    TTX_TRAP = 4'h1,
    TTX_XOR = 4'h2,
    TTX_PROBE = 4'h3,
    TTX_READ = 4'h4,
    TTX_WRI = 4'h5,
    TTX_WRR = 4'h6
  } ttx_op_e;
  typedef logic [63:0] ttx_word_t;
endpackage

// ==== logic/ttx_tlb_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// small tlb entry store with registered read and parallel match
module ttx_tlb_mem #(
  parameter int ENTRIES = 32,
  parameter int IW = 5
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [IW-1:0] waddr_i,
  input wire logic [63:0] wmask_i,
  input wire logic [63:0] whi_i,
  input wire logic [63:0] wlo0_i,
  input wire logic [63:0] wlo1_i,
  input wire logic wg_i,
  input wire logic [IW-1:0] raddr_i,
  input wire logic [63:0] probe_hi_i,
  output logic [63:0] rmask_o,
  output logic [63:0] rhi_o,
  output logic [63:0] rlo0_o,
  output logic [63:0] rlo1_o,
  output logic rg_o,
  output logic hit_o,
  output logic [IW-1:0] hit_idx_o
);
  `include "ttx_defines.svh"
  initial begin
    if (ENTRIES < 1 || ENTRIES > (1 << IW)) $error("bad tlb size");
  end
  // entry arrays
  logic [63:0] mask_ff [ENTRIES];
  logic [63:0] hi_ff [ENTRIES];
  logic [63:0] lo0_ff [ENTRIES];
  logic [63:0] lo1_ff [ENTRIES];
  logic [ENTRIES-1:0] g_ff;
  // write port, out-of-range index is dropped
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      g_ff <= '0;
    end else if (we_i && 32'(waddr_i) < ENTRIES) begin
      mask_ff[waddr_i] <= wmask_i;
      hi_ff[waddr_i] <= whi_i;
      lo0_ff[waddr_i] <= wlo0_i;
      lo1_ff[waddr_i] <= wlo1_i;
      g_ff[waddr_i] <= wg_i;
    end
  end
  // registered read
  always_ff @(posedge clk_i) begin
    if (32'(raddr_i) < ENTRIES) begin
      rmask_o <= mask_ff[raddr_i];
      rhi_o <= hi_ff[raddr_i] & ~mask_ff[raddr_i];
      rlo0_o <= lo0_ff[raddr_i];
      rlo1_o <= lo1_ff[raddr_i];
      rg_o <= g_ff[raddr_i];
    end else begin
      rmask_o <= '0;
      rhi_o <= '0;
      rlo0_o <= '0;
      rlo1_o <= '0;
      rg_o <= 1'b0;
    end
  end
  // combinational match, last match wins on multiple hits
  always_comb begin
    logic [63:0] m;
    m = '0;
    hit_o = 1'b0;
    hit_idx_o = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      m = ~(mask_ff[i] | 64'h0000_0000_0000_1fff);
      if (((hi_ff[i] ^ probe_hi_i) & m) == 64'h0 &&
          (g_ff[i] || hi_ff[i][7:0] == probe_hi_i[7:0])) begin
        hit_o = 1'b1;
        hit_idx_o = IW'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/ttx_exc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// exception unit stand-in: tallies trap requests and retirements
module ttx_exc_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic trap_req_i,
  input wire logic retire_i,
  output logic [7:0] trap_cnt_o,
  output logic [7:0] retire_cnt_o
);
  // a trap paired with a retire would be imprecise, so neither counts
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trap_cnt_o <= 8'h00;
      retire_cnt_o <= 8'h00;
    end else if (!(trap_req_i && retire_i)) begin
      trap_cnt_o <= trap_cnt_o + {7'h00, trap_req_i};
      retire_cnt_o <= retire_cnt_o + {7'h00, retire_i};
    end
  end
endmodule
`default_nettype wire

// ==== tb/trap_tlb_xor_execute_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ttx_defines.svh"
// bench for the trap, tlb maintenance and xor execute stage
module trap_tlb_xor_execute_test;
  import ttx_pkg::*;
  localparam ttx_word_t ONES = '1; // minus one as a register value
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic valid_i = 1'b0;
  logic mode64_i = 1'b1;
  logic cp_we_i = 1'b0;
  logic index_we_i = 1'b0;
  logic [31:0] instr_i = 32'h0;
  logic [31:0] index_wr_i = 32'h0;
  logic [4:0] random_i = 5'h00;
  logic [1:0] cp_sel_i = 2'h0;
  ttx_word_t src1_val_i = '0;
  ttx_word_t src2_val_i = '0;
  ttx_word_t cp_wdata_i = '0;
  logic trap_req_o, retire_o, gpr_we_o;
  logic [4:0] gpr_waddr_o;
  logic [31:0] index_o;
  ttx_word_t gpr_wdata_o, entry_high_reg_o, entry_low_even_reg_o;
  ttx_word_t entry_low_odd_reg_o, page_mask_reg_o;
  logic [7:0] trap_cnt;
  int fails = 0;
  int total_checks = 0;
  int exp_traps = 0;
  ttx_exec #(.ENTRIES(32), .IW(5)) ttx_exec_inst (.clk_i, .rst_n_i,
    .valid_i, .mode64_i, .instr_i, .src1_val_i, .src2_val_i, .random_i,
    .cp_we_i, .cp_sel_i, .index_wr_i, .index_we_i, .cp_wdata_i,
    .trap_req_o, .retire_o, .gpr_we_o, .gpr_waddr_o, .gpr_wdata_o,
    .index_o, .entry_high_reg_o, .entry_low_even_reg_o,
    .entry_low_odd_reg_o, .page_mask_reg_o);
  ttx_exc_model ttx_exc_model_inst (.clk_i, .rst_n_i,
    .trap_req_i(trap_req_o), .retire_i(retire_o),
    .trap_cnt_o(trap_cnt), .retire_cnt_o());
  // 20 ns period
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic summarize;
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one instruction for one cycle; returns in its answer cycle
  task automatic issue(input logic [31:0] ins, input ttx_word_t a,
                       input ttx_word_t b);
    @(posedge clk_i);
    #1;
    valid_i = 1'b1;
    instr_i = ins;
    src1_val_i = a;
    src2_val_i = b;
    @(posedge clk_i);
    #1;
    valid_i = 1'b0;
  endtask
  // control register write pulse
  task automatic cpw(input logic [1:0] s, input ttx_word_t d);
    @(posedge clk_i);
    #1;
    cp_we_i = 1'b1;
    cp_sel_i = s;
    cp_wdata_i = d;
    @(posedge clk_i);
    #1;
    cp_we_i = 1'b0;
  endtask
  task automatic idxw(input logic [31:0] v);
    @(posedge clk_i);
    #1;
    index_we_i = 1'b1;
    index_wr_i = v;
    @(posedge clk_i);
    #1;
    index_we_i = 1'b0;
  endtask
  function automatic logic [31:0] rr(input logic [5:0] f);
    return {6'h00, 5'h01, 5'h02, 10'h3ff, f}; // code field all ones
  endfunction
  function automatic logic [31:0] ri(input logic [4:0] s,
                                     input logic [15:0] m);
    return {`TTX_OP_REG_IMM, 5'h01, s, m};
  endfunction
  function automatic logic [31:0] cpi(input logic [5:0] f);
    return {`TTX_OP_SYS_COP, 1'b1, 19'h0, f};
  endfunction
  // trap or retire, never a destination write
  task automatic tcase(input logic [31:0] ins, input ttx_word_t a,
                       input ttx_word_t b, input logic m, input logic e);
    mode64_i = m;
    exp_traps += e;
    issue(ins, a, b);
    check({trap_req_o, retire_o, gpr_we_o}, {e, !e, 1'b0});
  endtask
  // load hi and both lows, then run a tlb operation
  task automatic tlbop(input ttx_word_t h, input ttx_word_t a,
                       input ttx_word_t b, input logic [5:0] f);
    cpw(2'h0, h);
    cpw(2'h1, a);
    cpw(2'h2, b);
    issue(cpi(f), '0, '0);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    check(index_o, 32'h0);
    check(page_mask_reg_o, 64'h0);
    tcase(rr(`TTX_FN_GE_U), 64'h5, 64'h5, 1'b1, 1'b1);
    tcase(rr(`TTX_FN_GE_U), 64'h4, 64'h5, 1'b1, 1'b0);
    tcase(rr(`TTX_FN_GE_U), ONES, 64'h1, 1'b1, 1'b1);
    tcase(rr(`TTX_FN_LT_S), ONES, 64'h1, 1'b1, 1'b1);
    tcase(rr(`TTX_FN_LT_S), 64'h1, ONES, 1'b1, 1'b0);
    tcase(rr(`TTX_FN_LT_U), 64'h1, ONES, 1'b1, 1'b1);
    tcase(rr(`TTX_FN_LT_U), 64'h5, 64'h5, 1'b1, 1'b0);
    tcase(rr(`TTX_FN_NE), 64'h5, 64'h5, 1'b1, 1'b0);
    tcase(rr(`TTX_FN_NE), 64'h5, 64'h6, 1'b1, 1'b1);
    tcase(ri(`TTX_SUB_LT_IMM_S, 16'hffff), 64'hfffffffffffffffe, '0,
          1'b1, 1'b1);
    tcase(ri(`TTX_SUB_LT_IMM_S, 16'h0000), 64'h1, '0, 1'b1, 1'b0);
    tcase(ri(`TTX_SUB_LT_IMM_U, 16'hffff), 64'hfffffffffffffff0, '0,
          1'b1, 1'b1);
    tcase(ri(`TTX_SUB_NE_IMM, 16'hffff), ONES, '0, 1'b1, 1'b0);
    tcase(ri(`TTX_SUB_NE_IMM, 16'hffff), 64'hffff, '0, 1'b1, 1'b1);
    tcase(rr(`TTX_FN_LT_U), 64'h100000001, 64'h2, 1'b0, 1'b1);
    tcase(rr(`TTX_FN_GE_U), 64'h80000000, 64'h100000000, 1'b0,
          1'b1);
    tcase(rr(`TTX_FN_NE), 64'h500000007, 64'h7, 1'b0, 1'b0);
    issue({6'h00, 5'h01, 5'h02, 5'h07, 5'h00, `TTX_FN_XOR},
          64'hf0f00000ffff1234, 64'h0ff0ffff0f0f4321);
    check({gpr_we_o, trap_req_o, gpr_waddr_o}, {2'h2, 5'h07});
    check(gpr_wdata_o, 64'hff00fffff0f05115);
    issue({`TTX_OP_XOR_IMM, 5'h01, 5'h09, 16'h8001}, 64'hffff << 48, '0);
    check({gpr_we_o, gpr_waddr_o}, {1'b1, 5'h09});
    check(gpr_wdata_o, 64'hffff000000008001);
    // give every entry a distinct page so probes never see stale data
    mode64_i = 1'b1;
    cpw(2'h3, '0);
    for (int i = 0; i < 32; i++) begin
      idxw(i);
      tlbop({35'h0, 16'h0100 + 16'(i), 13'h0}, '0, '0, `TTX_CP_WR_IDX);
    end
    idxw(32'h5);
    tlbop(64'h1234a055, 64'hcdef0001, 64'h34560002,
          `TTX_CP_WR_IDX);
    issue(cpi(`TTX_CP_PROBE), '0, '0);
    check(index_o, 32'h5);
    cpw(2'h0, 64'h1234a099);
    issue(cpi(`TTX_CP_PROBE), '0, '0);
    check(index_o[31], 1'b1);
    idxw(32'h5);
    cpw(2'h1, ONES);
    cpw(2'h2, ONES);
    cpw(2'h3, ONES);
    issue(cpi(`TTX_CP_READ), '0, '0);
    @(posedge clk_i);
    #1;
    check(page_mask_reg_o, 64'h0);
    check(entry_high_reg_o, 64'h1234a055);
    check(entry_low_even_reg_o, 64'hcdef0000);
    check(entry_low_odd_reg_o, 64'h34560002);
    random_i = 5'h09;
    cpw(2'h3, '0);
    tlbop(64'h5678a066, 64'h11, 64'h21, `TTX_CP_WR_RND);
    cpw(2'h0, 64'h5678a077);
    issue(cpi(`TTX_CP_PROBE), '0, '0);
    check(index_o, 32'h9);
    idxw(32'h9);
    issue(cpi(`TTX_CP_READ), '0, '0);
    @(posedge clk_i);
    #1;
    check({entry_low_even_reg_o, entry_low_odd_reg_o}, {64'h11, 64'h21});
    check(trap_cnt, exp_traps);
    summarize();
  end
endmodule
`default_nettype wire
